// ===== arsr_regs.v
// Read-only result and status register group of the accelerometer.
// Assumes register reads arrive as one-cycle strobes on mclk from the
// serial interface decoder, and all engine inputs are on mclk too.
// No input needs a synchroniser, and every output comes straight from a flop.
//
// Functional notes
// - After the Z low byte is read with locking on, the high byte stays frozen until it is read.
// - Coherent Z needs the lock-disable input low and the low byte read before the high byte.
// - Results are not to be trusted during power-up or the deepest sleep state.
// - Address 0x07 returns Z sample bits 11 down to 4 in bits 7 to 0.
// - Address 0x08 returns the 8-bit two's-complement temperature, zero meaning 23 C.
// - Each status flag is set when its interrupt engine triggers.
// - The 4-bit latch mode selects no hold, temporary hold or permanent hold of each flag.
// - Address 0x09 holds flat, orient, single tap, double tap, no-motion, slope, high-g, low-g.
// - Every status flag reads one when active and zero when inactive.
// - Address 0x0a holds data-ready, threshold and full in bits 7 to 5, the rest reserved.
// - The Z low byte holds sample bits 3 to 0 on top and a fresh-data flag in bit 0.
`include "arsr_defs.vh"
`default_nettype none

module arsr_regs #(
   parameter [15:0] HOLD_CYCLES = `ARSR_TEMP_HOLD_CYC
) (
   input wire mclk,                 // System clock, 40 MHz
   input wire rstn,                 // Async reset, active low
   input wire reg_rd,               // Register read strobe
   input wire reg_wr,               // Register write strobe
   input wire [7:0] reg_addr,       // Register address
   output reg [7:0] reg_rdata_r,    // Read data
   output reg reg_rvalid_r,         // Read data valid pulse
   output reg reg_wr_ignored_r,     // Write refused pulse
   input wire shadow_dis,           // Shadow lock disable
   input wire powerup_busy,         // Power-up in progress
   input wire deepest_sleep_state,  // Deepest suspend active
   input wire [11:0] z_sample,      // New Z sample, two's complement
   input wire z_sample_valid,       // Z sample strobe
   input wire [7:0] temp_sample,    // Die temperature
   input wire temp_sample_valid,    // Temperature strobe
   input wire [7:0] motion_trig,    // Motion engine trigger levels
   input wire data_ready_trig,      // Data-ready engine trigger
   input wire queue_threshold_event, // Queue threshold trigger
   input wire queue_full_trig,      // Queue full trigger
   input wire [3:0] latch_mode,     // Latch mode setting
   input wire latch_clear,          // Clear latched flags pulse
   output reg z_locked_r,           // High byte currently frozen
   output reg results_valid_r       // Results trustworthy
);

   // ======================================================================
   // Sample storage
   reg [11:0] z_live_r;
   reg [7:0] z_hold_r;
   reg z_fresh_r;
   reg [7:0] temp_r;
   reg [7:0] rd_mux;
   reg [7:0] z_high_view;
   wire [7:0] motion_flags;
   wire [2:0] queue_flags;
   wire [10:0] all_trig;
   wire [10:0] all_flags;
   wire sampling_ok = !powerup_busy && !deepest_sleep_state;
   wire rd_z_low = reg_rd && (reg_addr == `ARSR_ADDR_Z_LOW);
   wire rd_z_high = reg_rd && (reg_addr == `ARSR_ADDR_Z_HIGH);
   wire z_take = z_sample_valid && sampling_ok;

   // Results are only trusted outside power-up and deepest sleep
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         results_valid_r <= 1'b0;
      end else begin
         results_valid_r <= sampling_ok;
      end
   end

   // Live Z sample and temperature capture, frozen in low power states
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         z_live_r <= `ARSR_RST_SAMPLE;
         temp_r <= `ARSR_RST_BYTE;
      end else begin
         if (z_take) begin
            z_live_r <= z_sample;
         end
         if (temp_sample_valid && sampling_ok) begin
            temp_r <= temp_sample;
         end
      end
   end

   // Fresh-data flag: a new sample beats the clearing read
   // so a sample landing on the low-byte read is never lost
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         z_fresh_r <= 1'b0;
      end else if (z_take) begin
         z_fresh_r <= 1'b1;
      end else if (rd_z_low) begin
         z_fresh_r <= 1'b0;
      end
   end

   // ======================================================================
   // Shadow lock on the Z high byte
   // The copy is taken from z_live_r before any sample landing on the same edge,
   // so the frozen high byte matches the low byte returned by that read
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         z_locked_r <= 1'b0;
         z_hold_r <= `ARSR_RST_BYTE;
      end else if (shadow_dis) begin
         z_locked_r <= 1'b0;
         z_hold_r <= z_live_r[11:4];
      end else if (rd_z_low) begin
         z_locked_r <= 1'b1;
         z_hold_r <= z_live_r[11:4];
      end else if (rd_z_high) begin
         z_locked_r <= 1'b0;
      end
   end

   // High byte view: frozen copy while locked, live otherwise
   always @* begin
      if (z_locked_r) begin
         z_high_view = z_hold_r;
      end else begin
         z_high_view = z_live_r[11:4];
      end
   end

   // ======================================================================
   // Interrupt status flags
   // Cells 0 to 7 are the motion engines, 8 to 10 data-ready, threshold and full
   assign all_trig = {queue_full_trig, queue_threshold_event, data_ready_trig,
                      motion_trig};

   genvar gi;
   generate
      for (gi = 0; gi < 11; gi = gi + 1) begin : g_flag
         arsr_flag_cell #(
            .HOLD_CYCLES(HOLD_CYCLES)
         ) u_cell (
            .mclk(mclk),
            .rstn(rstn),
            .trig(all_trig[gi]),
            .mode(latch_mode),
            .clear(latch_clear),
            .flag_r(all_flags[gi])
         );
      end
   endgenerate

   assign motion_flags = all_flags[7:0];
   assign queue_flags = all_flags[10:8];

   // ======================================================================
   // Read data multiplexer
   // Reserved bits and unmapped addresses read as zero
   always @* begin
      rd_mux = `ARSR_RST_BYTE;
      case (reg_addr)
         `ARSR_ADDR_Z_LOW: begin
            rd_mux = {z_live_r[3:0], 3'h0, z_fresh_r};
         end
         `ARSR_ADDR_Z_HIGH: begin
            rd_mux = z_high_view;
         end
         `ARSR_ADDR_TEMP: begin
            rd_mux = temp_r;
         end
         `ARSR_ADDR_MOTION: begin
            rd_mux[`ARSR_MOT_FLAT] = motion_flags[7];
            rd_mux[`ARSR_MOT_ORIENT] = motion_flags[6];
            rd_mux[`ARSR_MOT_STAP] = motion_flags[5];
            rd_mux[`ARSR_MOT_DTAP] = motion_flags[4];
            rd_mux[`ARSR_MOT_NOMOT] = motion_flags[3];
            rd_mux[`ARSR_MOT_SLOPE] = motion_flags[2];
            rd_mux[`ARSR_MOT_HIGH] = motion_flags[1];
            rd_mux[`ARSR_MOT_LOW] = motion_flags[0];
         end
         `ARSR_ADDR_QUEUE: begin
            rd_mux[`ARSR_Q_DRDY] = queue_flags[0];
            rd_mux[`ARSR_Q_THRESH] = queue_flags[1];
            rd_mux[`ARSR_Q_FULL] = queue_flags[2];
         end
         default: begin
            rd_mux = `ARSR_RST_BYTE;
         end
      endcase
   end

   // Registered read answer, one cycle after the strobe
   // The data stays put between reads, so a slow host may pick it up late
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata_r <= `ARSR_RST_BYTE;
         reg_rvalid_r <= 1'b0;
      end else begin
         reg_rvalid_r <= reg_rd;
         if (reg_rd) begin
            reg_rdata_r <= rd_mux;
         end
      end
   end

   // Writes change nothing; they are only reported
   // Every bit here is read-only, so the strobe reaches no storage
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         reg_wr_ignored_r <= 1'b0;
      end else begin
         reg_wr_ignored_r <= reg_wr;
      end
   end

endmodule

`default_nettype wire

// ===== arsr_defs.vh
// Constants for the accelerometer readout and status register group.
// Assumes inclusion by bare name from the register group's design files.
`ifndef ARSR_DEFS_VH
`define ARSR_DEFS_VH

// ======================================================================
// Register offsets
`define ARSR_ADDR_Z_LOW 8'h06
`define ARSR_ADDR_Z_HIGH 8'h07
`define ARSR_ADDR_TEMP 8'h08
`define ARSR_ADDR_MOTION 8'h09
`define ARSR_ADDR_QUEUE 8'h0a

// ======================================================================
// Field positions
`define ARSR_MOT_FLAT 7
`define ARSR_MOT_ORIENT 6
`define ARSR_MOT_STAP 5
`define ARSR_MOT_DTAP 4
`define ARSR_MOT_NOMOT 3
`define ARSR_MOT_SLOPE 2
`define ARSR_MOT_HIGH 1
`define ARSR_MOT_LOW 0
`define ARSR_Q_DRDY 7
`define ARSR_Q_THRESH 6
`define ARSR_Q_FULL 5
`define ARSR_ZL_FRESH 0

// ======================================================================
// Latch-mode encodings
`define ARSR_LATCH_NONE 4'h0
`define ARSR_LATCH_PERM_A 4'h7
`define ARSR_LATCH_PERM_B 4'hf

// ======================================================================
// Reset values and timing
`define ARSR_RST_BYTE 8'h00
`define ARSR_RST_SAMPLE 12'h000
`define ARSR_MCLK_MHZ 40
`define ARSR_TEMP_HOLD_US 100
// Temporary hold of 100 us in 40 MHz cycles, sized to the 16-bit hold counter
`define ARSR_TEMP_HOLD_CYC 16'h0fa0

`endif

// ===== arsr_flag_cell.v
// One interrupt status flag with its latch behaviour.
// Assumes trigger, mode and clear all come from logic on mclk.
`include "arsr_defs.vh"
`default_nettype none

module arsr_flag_cell #(
   parameter [15:0] HOLD_CYCLES = 16'h0fa0  // 100 us at 40 MHz
) (
   input wire mclk,         // System clock
   input wire rstn,         // Async reset, active low
   input wire trig,         // Engine trigger level
   input wire [3:0] mode,   // Latch mode
   input wire clear,        // Latched flag clear pulse
   output reg flag_r        // Status flag, 1 = active
);

   reg [15:0] hold_r;
   wire perm = (mode == `ARSR_LATCH_PERM_A) || (mode == `ARSR_LATCH_PERM_B);
   wire none = (mode == `ARSR_LATCH_NONE);

   // ======================================================================
   // Flag update, trigger beats clear
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         flag_r <= 1'b0;
         hold_r <= 16'h0000;
      end else if (trig) begin
         flag_r <= 1'b1;
         hold_r <= HOLD_CYCLES;
      end else if (none) begin
         flag_r <= 1'b0;
         hold_r <= 16'h0000;
      end else if (clear) begin
         flag_r <= 1'b0;
         hold_r <= 16'h0000;
      end else if (!perm) begin
         if (hold_r != 16'h0000) begin
            hold_r <= hold_r - 16'h0001;
         end else begin
            flag_r <= 1'b0;
         end
      end
   end

endmodule

`default_nettype wire

// ===== arsr_host.sv
// Host model: strobes single register reads and writes.
// Assumes read data is valid one cycle after the read strobe.
`default_nettype none
module arsr_host (
   input wire logic mclk, // Clock
   input wire logic [7:0] rdata, // Read data
   input wire logic rvalid, // Read valid
   output var logic rd = 1'b0, // Read strobe
   output var logic wr = 1'b0, // Write strobe
   output var logic [7:0] addr = 8'h00 // Address
);
   timeunit 1ns;
   timeprecision 100ps;
   // ==========
   // Read: one strobe, bounded wait; low byte first keeps Z whole
   task automatic read(input logic [7:0] a, output logic [7:0] d, output logic late);
      int n;
      @(posedge mclk);
      rd <= 1'b1;
      addr <= a;
      @(posedge mclk);
      rd <= 1'b0;
      #1;
      for (n = 0; n < 4 && rvalid !== 1'b1; n++) begin
         @(posedge mclk);
         #1;
      end
      d = rdata;
      late = (rvalid !== 1'b1);
   endtask
   // Write strobe; no data lines, so reserved bits only ever see zero
   task automatic write(input logic [7:0] a);
      @(posedge mclk);
      wr <= 1'b1;
      addr <= a;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ===== arsr_regs_monitor.sv
// Checker for the result and status register group.
// Assumes a bind into arsr_regs; sees its ports only.
`default_nettype none
module arsr_regs_monitor (
   input wire logic mclk, // Clock
   input wire logic rstn, // Reset
   input wire logic reg_rd, // Read
   input wire logic reg_wr, // Write
   input wire logic [7:0] reg_addr, // Address
   input wire logic [7:0] reg_rdata_r, // Data
   input wire logic reg_rvalid_r, // Valid
   input wire logic reg_wr_ignored_r, // Refused
   input wire logic shadow_dis, // No lock
   input wire logic powerup_busy, // Waking
   input wire logic deepest_sleep_state, // Asleep
   input wire logic [7:0] motion_trig, // Triggers
   input wire logic [3:0] latch_mode, // Mode
   input wire logic z_locked_r, // Locked
   input wire logic results_valid_r // Trusted
);
   timeunit 1ns;
   timeprecision 100ps;
   // ==========
   // Read and write ports, Z lock, result trust and flag timing
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   chk_rd_answer: assert property (reg_rd |=> reg_rvalid_r)
      else $error("read unanswered");
   chk_no_stray: assert property (reg_rvalid_r |-> $past(reg_rd))
      else $error("stray valid");
   chk_wr_refused: assert property (reg_wr |=> reg_wr_ignored_r)
      else $error("write not refused");
   chk_resv_zero: assert property (reg_rd && reg_addr == 8'h0a
      |=> reg_rdata_r[4:0] == 5'h00) else $error("reserved bits set");
   chk_lock_take: assert property (reg_rd && reg_addr == 8'h06 && !shadow_dis
      |=> z_locked_r) else $error("lock not taken");
   chk_lock_free: assert property (reg_rd && reg_addr == 8'h07 || shadow_dis
      |=> !z_locked_r) else $error("lock kept");
   chk_trust_late: assert property ($past(rstn)
      |-> results_valid_r == !$past(powerup_busy || deepest_sleep_state)) else $error("trust");
   chk_flag_tracks: assert property (reg_rd && reg_addr == 8'h09 && latch_mode == 4'h0
      && $past(latch_mode) == 4'h0 && $past(rstn) |=> reg_rdata_r == $past(motion_trig, 2))
      else $error("flag not tracking");
   cov_lock_read: cover property (reg_rd && reg_addr == 8'h07 && z_locked_r);
   cov_refused: cover property (reg_wr_ignored_r);
   cov_held: cover property (latch_mode == 4'h7 && reg_rvalid_r && reg_rdata_r != 8'h00);
endmodule
bind arsr_regs arsr_regs_monitor mon_u (
   .mclk(mclk),
   .rstn(rstn),
   .reg_rd(reg_rd),
   .reg_wr(reg_wr),
   .reg_addr(reg_addr),
   .reg_rdata_r(reg_rdata_r),
   .reg_rvalid_r(reg_rvalid_r),
   .reg_wr_ignored_r(reg_wr_ignored_r),
   .shadow_dis(shadow_dis),
   .powerup_busy(powerup_busy),
   .deepest_sleep_state(deepest_sleep_state),
   .motion_trig(motion_trig),
   .latch_mode(latch_mode),
   .z_locked_r(z_locked_r),
   .results_valid_r(results_valid_r)
);
`default_nettype wire

// ===== arsr_tb.sv
// Bench: scripted register reads and writes with expected values.
// Assumes the host model and bound checker are compiled before it.
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic rd, wr, rv, zv, tv, sd, pb, ds, dr, qt, qf, lc, zl, rvd, wi;
   logic [7:0] addr, rdata, ts, mt;
   logic [11:0] zs;
   logic [3:0] lm;
   int n_mismatch = 0;
   int tests_run = 0;
   int i;
   // ==========
   // Clock, host model and design
   always #12.5 mclk = ~mclk;
   arsr_host host_u (.mclk(mclk), .rdata(rdata), .rvalid(rv), .rd(rd), .wr(wr), .addr(addr));
   arsr_regs #(.HOLD_CYCLES(16'h0008)) dut_u (.mclk(mclk), .rstn(rstn), .reg_rd(rd),
      .reg_wr(wr), .reg_addr(addr), .reg_rdata_r(rdata), .reg_rvalid_r(rv),
      .reg_wr_ignored_r(wi), .shadow_dis(sd), .powerup_busy(pb), .deepest_sleep_state(ds),
      .z_sample(zs), .z_sample_valid(zv), .temp_sample(ts), .temp_sample_valid(tv),
      .motion_trig(mt), .data_ready_trig(dr), .queue_threshold_event(qt),
      .queue_full_trig(qf), .latch_mode(lm), .latch_clear(lc), .z_locked_r(zl),
      .results_valid_r(rvd));
   // Verdict and end of run
   task automatic complete_run();
      if (n_mismatch == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // One read compared with its expected byte
   task automatic ck(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic late;
      host_u.read(a, d, late);
      tests_run++;
      if (late || d !== e) begin
         $display("unexpected reg %h: expected %h seen %h", a, e, d);
         n_mismatch++;
      end
      if (late)
         complete_run();
   endtask
   // One level output compared with its expected value
   task automatic ckb(input string nm, input logic e, input logic s);
      tests_run++;
      if (s !== e) begin
         $display("unexpected %s: expected %b seen %b", nm, e, s);
         n_mismatch++;
      end
   endtask
   // New Z and temperature samples on one strobe
   task automatic smp(input logic [11:0] z, input logic [7:0] t);
      @(posedge mclk);
      {zs, ts, zv, tv} <= {z, t, 2'b11};
      @(posedge mclk);
      {zv, tv} <= 2'b00;
   endtask
   // ==========
   // Scenarios
   initial begin
      {zv, tv, sd, pb, ds, dr, qt, qf, lc, zs, ts, mt, lm} <= 41'h0;
      repeat (8) @(posedge mclk);
      rstn <= 1'b1;
      smp(12'h123, 8'he7);
      ck(8'h06, 8'h31);
      ckb("z_locked", 1'b1, zl);
      smp(12'hab7, 8'hf6);
      ck(8'h07, 8'h12);
      ckb("z_locked", 1'b0, zl);
      ck(8'h06, 8'h71);
      ck(8'h07, 8'hab);
      ck(8'h06, 8'h70);
      ck(8'h08, 8'hf6);
      // Lock off: the high byte follows the newest sample
      @(posedge mclk);
      sd <= 1'b1;
      ck(8'h06, 8'h70);
      ckb("z_locked", 1'b0, zl);
      smp(12'h5c2, 8'hf6);
      ck(8'h07, 8'h5c);
      // Samples are dropped in deep sleep and during power-up
      @(posedge mclk);
      {sd, ds} <= 2'b01;
      smp(12'h000, 8'h11);
      #1 ckb("results_valid", 1'b0, rvd);
      @(posedge mclk);
      {ds, pb} <= 2'b01;
      smp(12'h000, 8'h11);
      #1 ckb("results_valid", 1'b0, rvd);
      @(posedge mclk);
      pb <= 1'b0;
      ck(8'h08, 8'hf6);
      ckb("results_valid", 1'b1, rvd);
      ck(8'h07, 8'h5c);
      host_u.write(8'h08);
      #1 ckb("wr_ignored", 1'b1, wi);
      ck(8'h08, 8'hf6);
      ck(8'h0b, 8'h00);
      // Unheld flags follow each driven engine one cycle late
      for (i = 0; i < 8; i++) begin
         @(posedge mclk);
         mt <= 8'h01 << i;
         ck(8'h09, 8'h01 << i);
      end
      for (i = 0; i < 3; i++) begin
         @(posedge mclk);
         {mt, dr, qt, qf} <= {8'h00, 3'b100 >> i};
         ck(8'h0a, 8'h80 >> i);
      end
      // Permanent hold in both encodings until cleared, then a temporary hold
      // that stands through its last counted cycle and then expires
      for (i = 0; i < 3; i++) begin
         @(posedge mclk);
         {dr, qt, qf, lm, mt} <= {3'b000, (i == 0) ? 4'h7 : (i == 1) ? 4'hf : 4'h1, 8'h04};
         @(posedge mclk);
         mt <= 8'h00;
         repeat (3) @(posedge mclk);
         ck(8'h09, 8'h04);
         @(posedge mclk);
         lc <= (i < 2);
         @(posedge mclk);
         lc <= 1'b0;
         ck(8'h09, (i < 2) ? 8'h00 : 8'h04);
         ck(8'h09, 8'h00);
      end
      complete_run();
   end
endmodule
`default_nettype wire
